// [core/dssl_direction_limit.sv]
// Behaviour
// - Direction setting change marks homing incomplete.
// - Speed/torque modes use start inputs, ignore setting.
// - Direction setting resets to zero.
// - Position mode: setting one reverses address direction.
// - Reversal internal, pulse inputs unchanged.
// - Active limit raises warning and stops motor.
// - Torque mode ignores limits except pole detection on linear/direct drive motors.
// - Continuous-to-torque honours limits only during detection.
// - Limit inputs are normally closed contacts.
// - Upper address limit blocks increasing addresses.
// - Lower address limit blocks decreasing addresses.
// - CCW stroke end blocks CCW/positive motion.
// - CW stroke end blocks CW/negative motion.
// - Limit stop may clear stored home position.
// - Report CCW stroke end as upper or lower.
module dssl_direction_limit
   import dssl_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   input  wire logic         dir_load,
   input  wire logic         dir_value,
   input  wire dssl_mode_e   control_mode,
   input  wire logic         cont_to_torque,
   input  wire logic         linear_or_dd_motor,
   input  wire logic         pole_detect_active,
   input  wire logic         home_clear_on_limit,
   input  wire logic         homing_done,
   input  wire logic         cmd_addr_inc,
   input  wire logic         cmd_addr_dec,
   input  wire logic         forward_run_start,
   input  wire logic         reverse_run_start,
   input  wire dssl_limits_s limit_pins,
   output logic              travel_direction_select,
   output dssl_motion_s      motor_drive,
   output dssl_warn_s        limit_warning,
   output logic              motor_stop,
   output logic              homing_incomplete,
   output logic              report_upper_limit,
   output logic              report_lower_limit
);

   dssl_limits_s sync1_ff;
   dssl_limits_s sync2_ff;
   logic         dir_ff;
   logic         nxt_dir;
   logic         home_inc_ff;
   logic         nxt_home_inc;
   dssl_motion_s drive_ff;
   dssl_motion_s nxt_drive;
   dssl_warn_s   warn_ff;
   dssl_warn_s   nxt_warn;
   dssl_state_e  state_ff;
   dssl_state_e  nxt_state;
   logic         rep_up_ff;
   logic         rep_lo_ff;
   logic         nxt_rep_up;
   logic         nxt_rep_lo;
   logic         stop_ff;
   logic         nxt_stop;

   // Inputs are open-contact-active; a low level means the limit is in force.
   function automatic logic dssl_active(input logic contact_n);
      dssl_active = ~contact_n;
   endfunction : dssl_active

   logic honour;
   logic lim_ccw;
   logic lim_cw;
   logic lim_up;
   logic lim_lo;
   logic want_ccw;
   logic want_cw;
   logic want_inc;
   logic want_dec;
   logic blk_ccw;
   logic blk_cw;

   always_comb
   begin
      lim_ccw = dssl_active(sync2_ff.ccw_stroke_end_n);
      lim_cw  = dssl_active(sync2_ff.cw_stroke_end_n);
      lim_up  = dssl_active(sync2_ff.upper_address_limit_n);
      lim_lo  = dssl_active(sync2_ff.lower_address_limit_n);
      // Pole detection on linear or direct drive motors is the only torque case with limits.
      if (control_mode == DSSL_MODE_TRQ || cont_to_torque)
      begin
         honour = pole_detect_active & linear_or_dd_motor;
      end
      else
      begin
         honour = 1'b1;
      end
      want_inc = 1'b0;
      want_dec = 1'b0;
      want_ccw = 1'b0;
      want_cw  = 1'b0;
      unique case (control_mode)
         DSSL_MODE_POS:
         begin
            want_inc = cmd_addr_inc & ~cmd_addr_dec;
            want_dec = cmd_addr_dec & ~cmd_addr_inc;
            want_ccw = dir_ff ? want_dec : want_inc;
            want_cw  = dir_ff ? want_inc : want_dec;
         end
         DSSL_MODE_SPD, DSSL_MODE_TRQ:
         begin
            want_ccw = forward_run_start & ~reverse_run_start;
            want_cw  = reverse_run_start & ~forward_run_start;
            want_inc = dir_ff ? want_cw : want_ccw;
            want_dec = dir_ff ? want_ccw : want_cw;
         end
         default:
         begin
         end
      endcase
      // Each limit only removes motion toward itself, so backing off stays possible.
      blk_ccw = honour & (lim_ccw | (want_inc & lim_up) | (want_dec & lim_lo));
      blk_cw  = honour & (lim_cw | (want_inc & lim_up) | (want_dec & lim_lo));
      nxt_drive.ccw = want_ccw & ~blk_ccw;
      nxt_drive.cw  = want_cw & ~blk_cw;
      nxt_warn.warn_ccw_stroke = honour & lim_ccw;
      nxt_warn.warn_cw_stroke  = honour & lim_cw;
      nxt_warn.warn_upper_addr = honour & lim_up;
      nxt_warn.warn_lower_addr = honour & lim_lo;
      if ((want_ccw & blk_ccw) | (want_cw & blk_cw))
      begin
         nxt_state = DSSL_ST_STOP;
      end
      else
      begin
         nxt_state = DSSL_ST_RUN;
      end
      nxt_stop = (nxt_state == DSSL_ST_STOP);
   end

   // Reset loads all limit inputs as open so motion is held off until the pins settle.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= limit_pins;
         sync2_ff <= sync1_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         drive_ff <= '0;
         warn_ff  <= '0;
         state_ff <= DSSL_ST_STOP;
         stop_ff  <= DSSL_STOP_RESET;
      end
      else
      begin
         drive_ff <= nxt_drive;
         warn_ff  <= nxt_warn;
         state_ff <= nxt_state;
         stop_ff  <= nxt_stop;
      end
   end

   always_comb
   begin
      nxt_dir = dir_load ? dir_value : dir_ff;
      nxt_home_inc = home_inc_ff;
      if (homing_done)
      begin
         nxt_home_inc = 1'b0;
      end
      // A setting change wins over a homing completion in the same cycle.
      if (dir_load && dir_value != dir_ff)
      begin
         nxt_home_inc = 1'b1;
      end
      if (home_clear_on_limit && nxt_state == DSSL_ST_STOP && state_ff == DSSL_ST_RUN)
      begin
         nxt_home_inc = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dir_ff      <= DSSL_DIR_DEFAULT;
         home_inc_ff <= DSSL_HOME_INC_RESET;
      end
      else
      begin
         dir_ff      <= nxt_dir;
         home_inc_ff <= nxt_home_inc;
      end
   end

   // Reports follow the stroke ends in every mode, so the controller sees them even when ignored.
   always_comb
   begin
      nxt_rep_up = dir_ff ? dssl_active(sync2_ff.cw_stroke_end_n)
                          : dssl_active(sync2_ff.ccw_stroke_end_n);
      nxt_rep_lo = dir_ff ? dssl_active(sync2_ff.ccw_stroke_end_n)
                          : dssl_active(sync2_ff.cw_stroke_end_n);
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rep_up_ff <= DSSL_REPORT_RESET;
         rep_lo_ff <= DSSL_REPORT_RESET;
      end
      else
      begin
         rep_up_ff <= nxt_rep_up;
         rep_lo_ff <= nxt_rep_lo;
      end
   end

   assign travel_direction_select = dir_ff;
   assign motor_drive             = drive_ff;
   assign limit_warning           = warn_ff;
   assign motor_stop              = stop_ff;
   assign homing_incomplete       = home_inc_ff;
   assign report_upper_limit      = rep_up_ff;
   assign report_lower_limit      = rep_lo_ff;

endmodule : dssl_direction_limit

// [core/dssl_pkg.sv]
package dssl_pkg;

   localparam logic       DSSL_DIR_DEFAULT = 1'b0;
   localparam logic       DSSL_HOME_INC_RESET = 1'b1;
   localparam logic       DSSL_STOP_RESET = 1'b1;
   localparam logic       DSSL_REPORT_RESET = 1'b0;

   typedef enum logic [2:0]
   {
      DSSL_MODE_POS  = 3'h1,
      DSSL_MODE_SPD  = 3'h2,
      DSSL_MODE_TRQ  = 3'h4
   } dssl_mode_e;

   typedef struct packed
   {
      logic ccw_stroke_end_n;
      logic cw_stroke_end_n;
      logic upper_address_limit_n;
      logic lower_address_limit_n;
   } dssl_limits_s;

   typedef struct packed
   {
      logic ccw;
      logic cw;
   } dssl_motion_s;

   typedef struct packed
   {
      logic warn_ccw_stroke;
      logic warn_cw_stroke;
      logic warn_upper_addr;
      logic warn_lower_addr;
   } dssl_warn_s;

   typedef enum logic [1:0]
   {
      DSSL_ST_RUN  = 2'h1,
      DSSL_ST_STOP = 2'h2
   } dssl_state_e;

endpackage : dssl_pkg

// [tb/direction_select_stroke_limit_bench.sv]
module direction_select_stroke_limit_bench;
   import dssl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic         ref_clk = 1'b0;
   logic         resetn = 1'b0;
   logic         dir_load, dir_value, cont_to_torque, linear_or_dd_motor, pole_detect_active;
   logic         home_clear_on_limit, homing_done, cmd_addr_inc, cmd_addr_dec, unlimited;
   logic         forward_run_start, reverse_run_start, travel_direction_select, motor_stop;
   logic         homing_incomplete, report_upper_limit, report_lower_limit;
   logic [3:0]   want = 4'hf;
   dssl_mode_e   control_mode = DSSL_MODE_POS;
   dssl_limits_s limit_pins;
   dssl_motion_s motor_drive;
   dssl_warn_s   limit_warning;
   int           miscompares = 0;
   int           n_tests = 0;
   dssl_direction_limit dut_u (.*);
   dssl_ctrl_model ctrl_u (.*);
   always #5 ref_clk = ~ref_clk;
   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic run(input logic [1:0] cmd, input int n);
      {cmd_addr_inc, cmd_addr_dec} = cmd;
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : run
   task automatic t_limit;
      {homing_done, home_clear_on_limit} = 2'h3;
      run(2'h2, 1);
      homing_done = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         want = ~(4'h1 << i);
         run(i[0] ? 2'h2 : 2'h1, 4);
         chk({motor_drive, motor_stop, limit_warning[i]}, 4'h3);
         chk({report_upper_limit, report_lower_limit, 2'h0}, {i == 3, i == 2, 2'h0});
         run(i[0] ? 2'h1 : 2'h2, 1);
         chk({motor_drive, motor_stop, 1'b0}, i[0] ? 4'h4 : 4'h8);
      end
      chk({homing_incomplete, 3'h0}, 4'h8);
   endtask : t_limit
   task automatic t_dir;
      homing_done = 1'b1;
      run(2'h1, 2);
      chk({motor_drive, homing_incomplete, travel_direction_select}, 4'h4);
      {homing_done, dir_load, dir_value} = 3'h7;
      run(2'h2, 1);
      chk({homing_incomplete, travel_direction_select, 2'h0}, 4'hc);
      {homing_done, dir_load} = 2'h0;
      run(2'h2, 2);
      chk({motor_drive, report_upper_limit, report_lower_limit}, 4'h5);
   endtask : t_dir
   task automatic t_trq;
      control_mode = DSSL_MODE_TRQ;
      {forward_run_start, linear_or_dd_motor} = 2'h3;
      want = 4'h0;
      run(2'h0, 4);
      chk({motor_drive, limit_warning[3:2]}, 4'h8);
      pole_detect_active = 1'b1;
      run(2'h0, 1);
      chk({motor_drive, motor_stop, 1'b0}, 4'h2);
      control_mode = DSSL_MODE_SPD;
      {cont_to_torque, pole_detect_active} = 2'h2;
      run(2'h0, 1);
      chk({motor_drive, 2'h0}, 4'h8);
      {cont_to_torque, unlimited} = 2'h1;
      run(2'h0, 5);
      chk({motor_drive, limit_warning[3:2]}, 4'h8);
      control_mode = DSSL_MODE_POS;
      run(2'h2, 2);
      chk({motor_drive, motor_stop, 1'b0}, 4'h4);
   endtask : t_trq
   task automatic close_out;
      if (miscompares == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : close_out
   initial
   begin
      {dir_load, dir_value, cont_to_torque, linear_or_dd_motor, pole_detect_active} = '0;
      {home_clear_on_limit, homing_done, cmd_addr_inc, cmd_addr_dec, unlimited} = '0;
      {forward_run_start, reverse_run_start} = '0;
      #26;
      chk({travel_direction_select, motor_stop, homing_incomplete, motor_drive.ccw}, 4'h6);
      resetn = 1'b1;
      t_limit;
      t_dir;
      t_trq;
      close_out;
   end
   initial
   begin
      #5000;
      miscompares++;
      close_out;
   end
endmodule : direction_select_stroke_limit_bench

// [tb/dssl_ctrl_model.sv]
module dssl_ctrl_model
   import dssl_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       unlimited,
   input wire logic [3:0] want,
   output dssl_limits_s   limit_pins
);
   timeunit 1ns;
   timeprecision 100ps;
   // Closed contacts mean no limit; an unlimited axis holds every contact closed.
   initial limit_pins = 4'hf;
   always @(posedge ref_clk)
      limit_pins <= #1 unlimited ? 4'hf : want;
endmodule : dssl_ctrl_model

// [tb/dssl_direction_limit_assertions.sv]
module dssl_direction_limit_assertions
   import dssl_pkg::*;
(
   input wire logic         ref_clk,
   input wire logic         resetn,
   input wire logic         dir_load,
   input wire logic         dir_value,
   input wire dssl_mode_e   control_mode,
   input wire logic         cont_to_torque,
   input wire logic         pole_detect_active,
   input wire logic         cmd_addr_inc,
   input wire logic         cmd_addr_dec,
   input wire logic         forward_run_start,
   input wire logic         reverse_run_start,
   input wire dssl_limits_s limit_pins,
   input wire logic         travel_direction_select,
   input wire dssl_motion_s motor_drive,
   input wire dssl_warn_s   limit_warning,
   input wire logic         motor_stop,
   input wire logic         homing_incomplete
);
   timeunit 1ns;
   timeprecision 100ps;
   // The pin synchroniser still shows limits for two edges after reset, so the first three edges are skipped.
   logic [1:0] up_ff;
   wire        ok  = up_ff == 2'h3;
   wire        pos = ok && !dir_load && !cont_to_torque && control_mode == DSSL_MODE_POS;
   wire        inc = cmd_addr_inc && !cmd_addr_dec;
   wire        dec = cmd_addr_dec && !cmd_addr_inc;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         up_ff <= 2'h0;
      end
      else
      begin
         up_ff <= up_ff + {1'b0, !ok};
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   chk_dir_change: assert property (dir_load && dir_value != travel_direction_select
      |=> homing_incomplete && travel_direction_select == $past(dir_value)) else $error("no rehome");
   chk_pos_map: assert property (pos && inc && $past(limit_pins, 2) == 4'hf
      && $past(limit_pins) == 4'hf |=> motor_drive == {!travel_direction_select,
      travel_direction_select}) else $error("bad address map");
   chk_upper_block: assert property (pos && inc && !$past(limit_pins[1], 2) && !$past(limit_pins[1])
      |=> motor_drive == 2'h0 && motor_stop && limit_warning[1]) else $error("upper open");
   chk_lower_block: assert property (pos && dec && !$past(limit_pins[0], 2) && !$past(limit_pins[0])
      |=> motor_drive == 2'h0 && limit_warning[0]) else $error("lower open");
   chk_ccw_block: assert property (pos && inc && !travel_direction_select && !$past(limit_pins[3], 2)
      && !$past(limit_pins[3]) |=> !motor_drive.ccw && limit_warning[3]) else $error("ccw open");
   chk_cw_block: assert property (pos && dec && !travel_direction_select && !$past(limit_pins[2], 2)
      && !$past(limit_pins[2]) |=> !motor_drive.cw) else $error("cw open");
   chk_back_off: assert property (pos && dec && $past(limit_pins, 2) == 4'hd && $past(limit_pins) == 4'hd
      |=> motor_drive == {travel_direction_select, !travel_direction_select} && !motor_stop)
      else $error("back off blocked");
   chk_trq_ignore: assert property (control_mode == DSSL_MODE_TRQ && !pole_detect_active
      && forward_run_start && !reverse_run_start |=> motor_drive == 2'h2 && limit_warning == 4'h0)
      else $error("torque limit seen");
   cov_stop: cover property (pos && $rose(motor_stop));
   cov_flip: cover property ($rose(travel_direction_select));
   cov_trq: cover property (control_mode == DSSL_MODE_TRQ && motor_drive.ccw);
endmodule : dssl_direction_limit_assertions

bind dssl_direction_limit dssl_direction_limit_assertions chk_u (.*);
